// ---- logic/pqs_scheduler.sv ----
// Egress priority queue scheduler for one switch port: priority to class mapping,
// four class queues, and a strict / weighted round robin picker feeding transmit.
// Assumes configuration ports are quasi-static levels and the transmit path accepts
// one descriptor per cycle when tx_ready is high.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Four egress classes 0..3 exist per port, class 3 ranking highest and class 0 lowest.
// - A programmable table holds one class entry for each user priority 0 through 7.
// - Each received frame goes into the class that the table gives for its priority.
// - After reset priorities 0 and 3 map to class 0 and priorities 1 and 2 to class 1.
// - After reset priorities 4 and 5 map to class 2 and priorities 6 and 7 to class 3.
// - Each class selects strict or weighted mode, and strict classes drain highest first.
// - A weighted class uses a 4-bit weight from 0 to 15.
// - The weight matters only in weighted mode and is ignored in strict mode.
// - A weighted class with weight 0 is never selected and acts closed.
// - An untagged frame takes the port default priority before the class lookup.
module pqs_scheduler
  import pqs_pkg::*;
#(
  parameter int DEPTH = PQS_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration
  input wire logic map_we,
  input wire logic [2:0] map_prio,
  input wire logic [1:0] map_class,
  input wire logic [2:0] default_prio,
  input wire logic [3:0] strict_mode,
  input wire logic [15:0] weights,
  // Arriving frames
  input wire logic rx_valid,
  input wire pqs_frame_type rx_frame,
  output logic rx_ready,
  // Transmit path
  output logic tx_valid,
  output pqs_tx_type tx_desc,
  input wire logic tx_ready,
  // Status
  output logic [15:0] class_map,
  output logic [3:0] class_nonempty
);

  if (DEPTH < 2) begin : g_depth_check
    $error("pqs_scheduler: DEPTH must be at least 2");
  end

  // ----------------------------------------------------------------
  // Priority to class table
  // ----------------------------------------------------------------
  logic [15:0] map_table;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      map_table <= PQS_MAP_RESET;
    end else if (map_we) begin
      map_table[2*map_prio +: 2] <= map_class;
    end
  end

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  // The class is resolved at enqueue, so a later table write only steers new frames.
  logic [2:0] eff_prio;
  logic [1:0] rx_class;
  logic [3:0] q_full;
  logic [3:0] q_empty;
  logic [3:0] q_push;
  logic [3:0] q_pop;
  logic [15:0] q_head [PQS_NUM_CLASSES];

  assign eff_prio = rx_frame.tagged_prio ? rx_frame.prio : default_prio;
  assign rx_class = map_table[2*eff_prio +: 2];
  // Ready stays combinational: it must follow the class of the frame on offer, and a
  // registered copy could only refuse whenever any class is full, starving the others.
  assign rx_ready = !q_full[rx_class];

  always_comb begin
    q_push = '0;
    q_push[rx_class] = rx_valid && !q_full[rx_class];
  end

  // ----------------------------------------------------------------
  // Class queues
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PQS_NUM_CLASSES; gi++) begin : g_queue
      pqs_class_queue #(
        .WIDTH(16),
        .DEPTH(DEPTH)
      ) u_queue (
        .clk(clk),
        .rstn(rstn),
        .push(q_push[gi]),
        .push_data(rx_frame.frame_id),
        .pop(q_pop[gi]),
        .head(q_head[gi]),
        .empty(q_empty[gi]),
        .full(q_full[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // A pick is made only when the output slot is free or being taken this cycle.
  logic slot_free;
  logic [3:0] eligible;
  logic [3:0] wrr_open;
  logic [3:0] credit_left;
  logic [1:0] rr_ptr;
  logic [3:0] credit [PQS_NUM_CLASSES];
  logic pick_valid;
  logic pick_is_wrr;
  logic [1:0] pick_class;
  logic [1:0] cand;

  assign slot_free = !tx_valid || tx_ready;

  always_comb begin
    for (int i = 0; i < PQS_NUM_CLASSES; i++) begin
      wrr_open[i] = !strict_mode[i] && (weights[4*i +: 4] != 4'h0);
      credit_left[i] = credit[i] != 4'h0;
      eligible[i] = !q_empty[i] && (strict_mode[i] || wrr_open[i]);
    end
  end

  always_comb begin
    pick_valid = 1'b0;
    pick_is_wrr = 1'b0;
    pick_class = 2'h0;
    cand = 2'h0;
    // Strict classes first, highest index wins.
    for (int i = 0; i < PQS_NUM_CLASSES; i++) begin
      if (eligible[i] && strict_mode[i]) begin
        pick_valid = 1'b1;
        pick_class = 2'(i);
      end
    end
    // Otherwise rotate from the round robin pointer among open weighted classes.
    if (!pick_valid) begin
      for (int k = PQS_NUM_CLASSES - 1; k >= 0; k--) begin
        cand = rr_ptr + 2'(k);
        if (eligible[cand]) begin
          pick_valid = 1'b1;
          pick_is_wrr = 1'b1;
          pick_class = cand;
        end
      end
    end
  end

  always_comb begin
    q_pop = '0;
    q_pop[pick_class] = pick_valid && slot_free;
  end

  // ----------------------------------------------------------------
  // Weighted round robin credits
  // ----------------------------------------------------------------
  // Credit counts frames left in this round; it reloads from the weight when the
  // class first gets service, so a weight change applies from the next round.
  logic [3:0] cur_credit;

  assign cur_credit = credit_left[pick_class] ? credit[pick_class] : weights[4*pick_class +: 4];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rr_ptr <= 2'h0;
      for (int i = 0; i < PQS_NUM_CLASSES; i++) begin
        credit[i] <= 4'h0;
      end
    end else if (pick_valid && pick_is_wrr && slot_free) begin
      if (cur_credit == 4'h1) begin
        credit[pick_class] <= 4'h0;
        rr_ptr <= pick_class + 2'h1;
      end else begin
        credit[pick_class] <= cur_credit - 4'h1;
        rr_ptr <= pick_class;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit output
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_valid <= 1'b0;
      tx_desc <= '0;
    end else if (slot_free) begin
      tx_valid <= pick_valid;
      if (pick_valid) begin
        tx_desc.traffic_class_index <= pick_class;
        tx_desc.frame_id <= q_head[pick_class];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      class_map <= PQS_MAP_RESET;
      class_nonempty <= 4'h0;
    end else begin
      class_map <= map_table;
      class_nonempty <= ~q_empty;
    end
  end

endmodule // pqs_scheduler

`default_nettype wire

// ---- logic/pqs_pkg.sv ----
// Package for the egress priority queue scheduler: widths, reset values, carriers.
// Assumes a single switch clock; included by every design file of the block.
package pqs_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PQS_NUM_CLASSES = 4;
  localparam int PQS_NUM_PRIOS = 8;
  localparam int PQS_CLASS_W = 2;
  localparam int PQS_PRIO_W = 3;
  localparam int PQS_WEIGHT_W = 4;
  localparam int PQS_DEPTH = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  // Entry n of the table sits at bits [2n+1:2n]; priorities 7..0 map to 3,3,2,2,0,1,1,0.
  localparam logic [15:0] PQS_MAP_RESET = 16'hFA14;
  localparam logic [2:0] PQS_DEFAULT_PRIO_RESET = 3'h0;
  localparam logic [3:0] PQS_WEIGHT_RESET = 4'h1;
  localparam logic [3:0] PQS_STRICT_RESET = 4'hF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tagged_prio;
    logic [2:0] prio;
    logic [15:0] frame_id;
  } pqs_frame_type;

  typedef struct packed {
    logic [1:0] traffic_class_index;
    logic [15:0] frame_id;
  } pqs_tx_type;

endpackage : pqs_pkg

// ---- logic/pqs_class_queue.sv ----
// One per-class frame descriptor queue.
// Assumes push is only raised while not full and pop only while not empty.
`timescale 1ns/1ps
`default_nettype none

module pqs_class_queue
  import pqs_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = PQS_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic empty,
  output logic full
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("pqs_class_queue: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  assign head = mem[rd_ptr[AW-1:0]];
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);

endmodule // pqs_class_queue

`default_nettype wire

// ---- tb/pqs_checker.sv ----
// Port checker for the egress scheduler, bound to pqs_scheduler.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pqs_checker
  import pqs_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic rstn,
  input wire logic map_we,
  input wire logic [2:0] map_prio,
  input wire logic [1:0] map_class,
  input wire logic [3:0] strict_mode,
  input wire logic [15:0] weights,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire pqs_tx_type tx_desc,
  input wire logic tx_ready,
  input wire logic [15:0] class_map,
  input wire logic [3:0] class_nonempty
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_hold; tx_valid && !tx_ready |=> tx_valid; endproperty
  a_hold: assert property (p_hold) else $error("offer dropped");
  property p_desc; tx_valid && !tx_ready |=> $stable(tx_desc); endproperty
  a_desc: assert property (p_desc) else $error("offer changed");
  property p_map;
    map_we ##1 !map_we |-> ##1 class_map[2*$past(map_prio, 2) +: 2] == $past(map_class, 2);
  endproperty
  a_map: assert property (p_map) else $error("table write lost");
  property p_w0;
    tx_valid && !strict_mode[tx_desc.traffic_class_index] |->
      weights[4*tx_desc.traffic_class_index +: 4] != 4'h0;
  endproperty
  a_w0: assert property (p_w0) else $error("closed class sent");
  property p_rst; $rose(rstn) |-> class_map == 16'hFA14 && !tx_valid; endproperty
  a_rst: assert property (p_rst) else $error("bad reset table");
  property p_enq; rx_valid && rx_ready && !tx_valid && !tx_ready |-> ##2 class_nonempty != 4'h0; endproperty
  a_enq: assert property (p_enq) else $error("frame not queued");
  property p_rdy; !rx_ready |-> class_nonempty != 4'h0; endproperty
  a_rdy: assert property (p_rdy) else $error("refused while empty");
  property p_idle;
    !rx_valid && !$past(rx_valid) && class_nonempty == 4'h0 && !tx_valid |=> !tx_valid;
  endproperty
  a_idle: assert property (p_idle) else $error("sent from empty");
endmodule // pqs_checker
bind pqs_scheduler pqs_checker i_pqs_checker (.clk(clk), .rstn(rstn), .map_we(map_we),
  .map_prio(map_prio), .map_class(map_class), .strict_mode(strict_mode), .weights(weights),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_desc(tx_desc),
  .tx_ready(tx_ready), .class_map(class_map), .class_nonempty(class_nonempty));
`default_nettype wire

// ---- tb/pqs_tx_sink.sv ----
// Transmit path model: takes descriptors unless stalled and records them.
// Assumes stall is driven just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pqs_tx_sink
  import pqs_pkg::*;
(
  // Transmit side
  input wire logic clk,
  input wire logic stall,
  input wire logic tx_valid,
  input wire pqs_tx_type tx_desc,
  output logic tx_ready
);
  pqs_tx_type got[$];
  assign tx_ready = !stall;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_desc);
    end
  end
endmodule // pqs_tx_sink
`default_nettype wire

// ---- tb/priority_queue_scheduler_tb.sv ----
// Self-checking bench for pqs_scheduler with a stallable transmit model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module priority_queue_scheduler_tb
  import pqs_pkg::*;
;
  logic clk, rstn, map_we, rx_valid, rx_ready, tx_valid, tx_ready, stall, took;
  logic [2:0] map_prio, default_prio;
  logic [1:0] map_class;
  logic [3:0] strict_mode, class_nonempty;
  logic [15:0] weights, class_map;
  pqs_frame_type rx_frame;
  pqs_tx_type tx_desc;
  int n_fail, tests_run;
  pqs_scheduler i_pqs_scheduler (.clk(clk), .rstn(rstn), .map_we(map_we), .map_prio(map_prio),
    .map_class(map_class), .default_prio(default_prio), .strict_mode(strict_mode), .weights(weights),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_desc(tx_desc), .tx_ready(tx_ready), .class_map(class_map), .class_nonempty(class_nonempty));
  pqs_tx_sink i_pqs_tx_sink (.clk(clk), .stall(stall), .tx_valid(tx_valid), .tx_desc(tx_desc),
    .tx_ready(tx_ready));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // The valid line stays up between frames so it is never assigned twice in a step.
  task send(input logic t, input logic [2:0] p, input logic [15:0] id);
    rx_frame = {t, p, id};
    rx_valid = 1'b1;
    #1 took = rx_ready;
    @(posedge clk);
    #2;
  endtask
  task drain(input int n);
    int k;
    rx_valid = 1'b0;
    stall = 1'b0;
    for (k = 0; k < 200 && i_pqs_tx_sink.got.size() < n; k++) begin
      @(posedge clk);
      #2;
    end
    stall = 1'b1;
  endtask
  task take(input logic [1:0] c, input logic [15:0] id);
    chk("tx_desc", {c, id}, i_pqs_tx_sink.got.size() > 0 ? {2'h0, i_pqs_tx_sink.got.pop_front()} : 20'hFFFFF);
  endtask
  task wmap(input logic [2:0] p, input logic [1:0] c);
    map_prio = p;
    map_class = c;
    map_we = 1'b1;
    @(posedge clk);
    #2 map_we = 1'b0;
    @(posedge clk);
    #2;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_strict;
    logic [4:0] ord [8] = '{5'h00, 5'h1E, 5'h1F, 5'h14, 5'h15, 5'h09, 5'h0A, 5'h03};
    chk("class_map", 16'hFA14, class_map);
    weights = 16'h0000;
    for (int p = 0; p < 8; p++) send(1'b1, 3'(p), 16'h0010 + 16'(p));
    drain(8);
    for (int k = 0; k < 8; k++) take(ord[k][4:3], 16'h0010 + 16'(ord[k][2:0]));
    default_prio = 3'h5;
    send(1'b0, 3'h1, 16'h0021);
    drain(1);
    take(2'h2, 16'h0021);
  endtask
  task t_wrr;
    logic [15:0] nx [4] = '{16'h0031, 16'h0034, 16'h0037, 16'h0038};
    logic [13:0] seq;
    pqs_tx_type d;
    seq = 14'h0000;
    strict_mode = 4'h8;
    weights = 16'h0012;
    for (int k = 0; k < 8; k++) send(1'b1, k < 3 ? 3'h0 : k < 6 ? 3'h1 : k < 7 ? 3'h4 : 3'h6, 16'h0031 + 16'(k));
    drain(8);
    chk("count", 20'h7, 20'(i_pqs_tx_sink.got.size()));
    for (int k = 0; i_pqs_tx_sink.got.size() > 0; k++) begin
      d = i_pqs_tx_sink.got.pop_front();
      seq = {seq[11:0], d.traffic_class_index};
      if (k == 1) chk("strict_first", 20'h3, 20'(d.traffic_class_index));
      chk("closed", 20'h0, 20'(d.traffic_class_index == 2'h2));
      chk("fifo", {d.traffic_class_index, nx[d.traffic_class_index]}, 20'(d));
      nx[d.traffic_class_index]++;
    end
    // Class 0 opens its turn of two before class 3 arrives, strict class 3 cuts in,
    // class 0 finishes its turn, then turns of one and two alternate until class 1 is alone.
    chk("wrr_order", 20'h00C45, 20'(seq));
    chk("nonempty", 20'h1, 20'(class_nonempty[2]));
    weights = 16'h0F12;
    drain(1);
    take(2'h2, 16'h0037);
  endtask
  task t_remap;
    int n;
    strict_mode = 4'hF;
    send(1'b1, 3'h6, 16'h0041);
    rx_valid = 1'b0;
    wmap(3'h6, 2'h0);
    chk("class_map", 16'hCA14, class_map);
    send(1'b1, 3'h6, 16'h0042);
    send(1'b1, 3'h7, 16'h0043);
    drain(3);
    take(2'h3, 16'h0041);
    take(2'h3, 16'h0043);
    take(2'h0, 16'h0042);
    wmap(3'h6, 2'h3);
    n = 0;
    for (int k = 0; k < 10; k++) begin
      send(1'b1, 3'h7, 16'h0050 + 16'(k));
      if (took === 1'b1) n++;
    end
    // One frame waits in the output register, so a full queue plus one are taken.
    chk("accepted", 20'(PQS_DEPTH + 1), 20'(n));
    chk("rx_ready", 20'h0, 20'(rx_ready));
    drain(n);
    for (int k = 0; k < n; k++) take(2'h3, 16'h0050 + 16'(k));
  endtask
  task close_out;
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
  initial begin
    {rstn, map_we, rx_valid, took, map_prio, map_class, default_prio, rx_frame} = '0;
    {n_fail, tests_run} = '0;
    stall = 1'b1;
    strict_mode = 4'hF;
    weights = 16'h1111;
    repeat (5) @(posedge clk);
    #2 rstn = 1'b1;
    t_strict();
    t_wrr();
    t_remap();
    close_out();
  end
endmodule // priority_queue_scheduler_tb
`default_nettype wire
